// ### core/dpbr_mem.sv
`timescale 1ns/1ps
module dpbr_mem
  import dpbr_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // write side, one lane per port
  input wire logic [NPORTS-1:0] memWe,
  input wire logic [NPORTS-1:0][ADDR_W-1:0] memAddr,
  input wire logic [NPORTS-1:0][DATA_W-1:0] memWrData,
  input wire logic [NPORTS-1:0][EXTRA_W-1:0] memWrExtra,
  // contents before the edge
  output logic [NPORTS-1:0][DATA_W-1:0] memRdData,
  output logic [NPORTS-1:0][EXTRA_W-1:0] memRdExtra
);
  logic [DATA_W-1:0] dataMem [DEPTH];
  logic [EXTRA_W-1:0] extraMem [DEPTH];

  // port b is written last, so it wins a same-address collision
  always_ff @(posedge clk_sys) begin
    for (int p = 0; p < NPORTS; p++) begin
      if (memWe[p]) begin
        dataMem[memAddr[p]] <= memWrData[p];
        extraMem[memAddr[p]] <= memWrExtra[p];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NPORTS; g++) begin : gRd
      assign memRdData[g] = dataMem[memAddr[g]];
      assign memRdExtra[g] = extraMem[memAddr[g]];
    end
  endgenerate
endmodule

// ### core/dpbr_pkg.sv
package dpbr_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned EXTRA_W = 4;
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DEPTH = 512;
  localparam int unsigned NPORTS = 2;
  // preload image sizes: 512 content words of 32 bits and 512 extra words of 4 bits each
  localparam int unsigned CONTENT_BITS = 16384;
  localparam int unsigned EXTRA_BITS = 2048;
  localparam logic [ADDR_W-1:0] LAST_ADDR = 9'h1ff;

  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FORCE_A = 8'h04;
  localparam logic [7:0] OFS_FORCE_B = 8'h08;
  localparam logic [7:0] OFS_START_A = 8'h0c;
  localparam logic [7:0] OFS_START_B = 8'h10;
  localparam logic [7:0] OFS_EXTRA = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // field positions
  localparam int unsigned CTRL_POL_A = 0;
  localparam int unsigned CTRL_POL_B = 2;
  localparam int unsigned EXTRA_FORCE_A = 0;
  localparam int unsigned EXTRA_FORCE_B = 4;
  localparam int unsigned EXTRA_START_A = 8;
  localparam int unsigned EXTRA_START_B = 12;
  localparam int unsigned STAT_DONE = 0;
  localparam int unsigned STAT_DEFINED = 1;
  localparam int unsigned STAT_INVALID = 3;

  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] VALUE_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    POL_WRITE_FIRST = 2'h0,
    POL_READ_FIRST = 2'h1,
    POL_NO_CHANGE = 2'h2,
    POL_SPARE = 2'h3
  } dpbr_pol_t;

  typedef enum logic [1:0] {
    ST_PRELOAD = 2'b01,
    ST_RUN = 2'b10
  } dpbr_state_t;
endpackage

// ### core/dpbr_top.sv
`timescale 1ns/1ps
module dpbr_top
  import dpbr_pkg::*;
#(
  parameter logic [CONTENT_BITS-1:0] CONTENT_PRELOAD_WORDS = '0,
  parameter logic [EXTRA_BITS-1:0] EXTRA_PRELOAD_WORDS = '0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // global set/reset
  input wire logic globalSetReset,
  // memory ports, index 0 is port a, index 1 is port b
  input wire logic [NPORTS-1:0] portEn,
  input wire logic [NPORTS-1:0] portWe,
  input wire logic [NPORTS-1:0] outputForce,
  input wire logic [NPORTS-1:0][dpbr_pkg::ADDR_W-1:0] portAddr,
  input wire logic [NPORTS-1:0][dpbr_pkg::DATA_W-1:0] writeWordIn,
  input wire logic [NPORTS-1:0][dpbr_pkg::EXTRA_W-1:0] extraBitsIn,
  output logic [NPORTS-1:0][dpbr_pkg::DATA_W-1:0] dataOut,
  output logic [NPORTS-1:0][dpbr_pkg::EXTRA_W-1:0] extraBitsOut,
  output logic [NPORTS-1:0] outInvalid,
  output logic [NPORTS-1:0] outDefined,
  output logic preloadDone
);
  import dpbr_pkg::*;

  // ---------------- apb register file
  logic [31:0] ctrl_reg;
  logic [31:0] forceA_reg;
  logic [31:0] forceB_reg;
  logic [31:0] startA_reg;
  logic [31:0] startB_reg;
  logic [31:0] extra_reg;

  wire apbAccess = psel & penable;
  wire selCtrl = (paddr == OFS_CTRL);
  wire selForceA = (paddr == OFS_FORCE_A);
  wire selForceB = (paddr == OFS_FORCE_B);
  wire selStartA = (paddr == OFS_START_A);
  wire selStartB = (paddr == OFS_START_B);
  wire selExtra = (paddr == OFS_EXTRA);
  wire selStatus = (paddr == OFS_STATUS);
  wire selWritable = selCtrl | selForceA | selForceB | selStartA | selStartB | selExtra;
  wire selAny = selWritable | selStatus;
  wire apbWr = apbAccess & pwrite & selWritable;

  logic [31:0] statusWord;
  assign statusWord = {27'h0, outInvalid, outDefined, preloadDone};

  assign pready = 1'b1;
  // unmapped addresses and writes to the status word are flagged
  assign pslverr = apbAccess & (~selAny | (pwrite & selStatus));
  assign prdata = ~(apbAccess & ~pwrite) ? 32'h0 :
                  selCtrl ? ctrl_reg :
                  selForceA ? forceA_reg :
                  selForceB ? forceB_reg :
                  selStartA ? startA_reg :
                  selStartB ? startB_reg :
                  selExtra ? extra_reg :
                  selStatus ? statusWord : 32'h0;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= CTRL_RESET;
      forceA_reg <= VALUE_RESET;
      forceB_reg <= VALUE_RESET;
      startA_reg <= VALUE_RESET;
      startB_reg <= VALUE_RESET;
      extra_reg <= VALUE_RESET;
    end else if (apbWr) begin
      if (selCtrl) ctrl_reg <= {28'h0, pwdata[3:0]};
      if (selForceA) forceA_reg <= pwdata;
      if (selForceB) forceB_reg <= pwdata;
      if (selStartA) startA_reg <= pwdata;
      if (selStartB) startB_reg <= pwdata;
      if (selExtra) extra_reg <= {16'h0, pwdata[15:0]};
    end
  end

  // per-port views of the configuration
  logic [NPORTS-1:0][1:0] portPol;
  logic [NPORTS-1:0][DATA_W-1:0] forcedData;
  logic [NPORTS-1:0][EXTRA_W-1:0] forcedExtra;
  logic [NPORTS-1:0][DATA_W-1:0] startData;
  logic [NPORTS-1:0][EXTRA_W-1:0] startExtra;
  assign portPol[0] = ctrl_reg[CTRL_POL_A +: 2];
  assign portPol[1] = ctrl_reg[CTRL_POL_B +: 2];
  assign forcedData[0] = forceA_reg;
  assign forcedData[1] = forceB_reg;
  assign forcedExtra[0] = extra_reg[EXTRA_FORCE_A +: EXTRA_W];
  assign forcedExtra[1] = extra_reg[EXTRA_FORCE_B +: EXTRA_W];
  assign startData[0] = startA_reg;
  assign startData[1] = startB_reg;
  assign startExtra[0] = extra_reg[EXTRA_START_A +: EXTRA_W];
  assign startExtra[1] = extra_reg[EXTRA_START_B +: EXTRA_W];

  // ---------------- preload sequencer
  dpbr_state_t state_reg;
  dpbr_state_t state_next;
  logic [ADDR_W-1:0] loadAddr_reg;
  logic [ADDR_W-1:0] loadAddr_next;
  wire loading = (state_reg == ST_PRELOAD);

  always_comb begin
    state_next = state_reg;
    loadAddr_next = loadAddr_reg;
    case (state_reg)
      ST_PRELOAD: begin
        loadAddr_next = loadAddr_reg + 9'h001;
        if (loadAddr_reg == LAST_ADDR) state_next = ST_RUN;
      end
      ST_RUN: state_next = ST_RUN;
      default: state_next = ST_PRELOAD;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_PRELOAD;
      loadAddr_reg <= '0;
    end else begin
      state_reg <= state_next;
      loadAddr_reg <= loadAddr_next;
    end
  end
  assign preloadDone = (state_reg == ST_RUN);

  wire [DATA_W-1:0] loadWord = CONTENT_PRELOAD_WORDS[loadAddr_reg*DATA_W +: DATA_W];
  wire [EXTRA_W-1:0] loadExtra = EXTRA_PRELOAD_WORDS[loadAddr_reg*EXTRA_W +: EXTRA_W];

  // ---------------- memory
  logic [NPORTS-1:0] portGo;
  logic [NPORTS-1:0] portWrite;
  logic [NPORTS-1:0] memWe;
  logic [NPORTS-1:0][ADDR_W-1:0] memAddr;
  logic [NPORTS-1:0][DATA_W-1:0] memWrData;
  logic [NPORTS-1:0][EXTRA_W-1:0] memWrExtra;
  logic [NPORTS-1:0][DATA_W-1:0] memRdData;
  logic [NPORTS-1:0][EXTRA_W-1:0] memRdExtra;

  dpbr_mem u_mem (
    .clk_sys(clk_sys),
    .memWe(memWe),
    .memAddr(memAddr),
    .memWrData(memWrData),
    .memWrExtra(memWrExtra),
    .memRdData(memRdData),
    .memRdExtra(memRdExtra)
  );

  // ---------------- per-port datapath
  genvar g;
  generate
    for (g = 0; g < NPORTS; g++) begin : gPort
      localparam int OTHER = NPORTS - 1 - g;
      logic [DATA_W-1:0] dout_reg;
      logic [DATA_W-1:0] dout_next;
      logic [EXTRA_W-1:0] xout_reg;
      logic [EXTRA_W-1:0] xout_next;
      logic invalid_reg;
      logic defined_reg;
      wire otherClash;

      // ports are ignored while the preload runs
      assign portGo[g] = portEn[g] & preloadDone;
      assign portWrite[g] = portGo[g] & portWe[g];
      if (g == 0) begin : gLoadMux
        assign memWe[g] = loading | portWrite[g];
        assign memAddr[g] = loading ? loadAddr_reg : portAddr[g];
        assign memWrData[g] = loading ? loadWord : writeWordIn[g];
        assign memWrExtra[g] = loading ? loadExtra : extraBitsIn[g];
      end else begin : gPlain
        assign memWe[g] = portWrite[g];
        assign memAddr[g] = portAddr[g];
        assign memWrData[g] = writeWordIn[g];
        assign memWrExtra[g] = extraBitsIn[g];
      end

      // the other port writes our address under a policy that does not show old data
      assign otherClash = portWrite[OTHER] & (portAddr[OTHER] == portAddr[g]) &
                          (portPol[OTHER] != POL_READ_FIRST);

      always_comb begin
        dout_next = dout_reg;
        xout_next = xout_reg;
        if (globalSetReset) begin
          dout_next = startData[g];
          xout_next = startExtra[g];
        end else if (portGo[g]) begin
          if (outputForce[g]) begin
            dout_next = forcedData[g];
            xout_next = forcedExtra[g];
          end else if (!portWe[g]) begin
            dout_next = memRdData[g];
            xout_next = memRdExtra[g];
          end else begin
            case (portPol[g])
              POL_READ_FIRST: begin
                dout_next = memRdData[g];
                xout_next = memRdExtra[g];
              end
              POL_NO_CHANGE: begin
                dout_next = dout_reg;
                xout_next = xout_reg;
              end
              default: begin
                dout_next = writeWordIn[g];
                xout_next = extraBitsIn[g];
              end
            endcase
          end
        end
      end

      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          dout_reg <= '0;
          xout_reg <= '0;
          invalid_reg <= 1'b0;
          defined_reg <= 1'b0;
        end else begin
          dout_reg <= dout_next;
          xout_reg <= xout_next;
          if (globalSetReset) begin
            invalid_reg <= 1'b0;
            defined_reg <= 1'b1;
          end else if (portGo[g]) begin
            invalid_reg <= otherClash & ~outputForce[g] & ~(portWe[g] &
                           (portPol[g] == POL_NO_CHANGE));
            defined_reg <= 1'b1;
          end
        end
      end

      assign dataOut[g] = dout_reg;
      assign extraBitsOut[g] = xout_reg;
      assign outInvalid[g] = invalid_reg;
      assign outDefined[g] = defined_reg;
    end
  endgenerate

  // ---------------- assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_PRELOAD_END: assert property (loading && loadAddr_reg == LAST_ADDR
    |=> preloadDone ##1 preloadDone)
    else $error("preload did not finish after last address");
  AST_PRELOAD_EXTRA: assert property (loading
    |=> u_mem.extraMem[$past(loadAddr_reg)] ==
    EXTRA_PRELOAD_WORDS[$past(loadAddr_reg)*EXTRA_W +: EXTRA_W])
    else $error("extra preload word not written");
  AST_GSR: assert property (globalSetReset
    |=> dataOut[1] == $past(startData[1]) && outDefined[1])
    else $error("start value not loaded on global set reset");
  AST_FORCE: assert property (!globalSetReset && portGo[0] && outputForce[0]
    && !portWe[0] |=> dataOut[0] == $past(forcedData[0]) &&
    extraBitsOut[0] == $past(forcedExtra[0]))
    else $error("forced value not loaded");
  AST_FORCE_WRITE: assert property (!globalSetReset && portGo[1] && outputForce[1]
    && portWe[1] |-> memWe[1] ##1 dataOut[1] == $past(forcedData[1]))
    else $error("forced write lost data or output");
  AST_INDEPENDENT: assert property (portGo[1] && !portGo[0] && !globalSetReset
    |=> $stable(dataOut[0]))
    else $error("idle port output moved");
  AST_WRITE: assert property (portWrite[1] && !(portWrite[0] && portAddr[0] == portAddr[1])
    |=> u_mem.dataMem[$past(portAddr[1])] == $past(writeWordIn[1]))
    else $error("write data not stored");
  AST_READ: assert property (!globalSetReset && portGo[0] && !outputForce[0]
    && !portWe[0] |=> dataOut[0] == $past(memRdData[0]))
    else $error("read data not latched");
  AST_WRITE_FIRST: assert property (!globalSetReset && portWrite[0] && !outputForce[0] &&
    portPol[0] == POL_WRITE_FIRST |=> dataOut[0] == $past(writeWordIn[0]))
    else $error("write-then-show output wrong");
  AST_READ_FIRST: assert property (!globalSetReset && portWrite[1] && !outputForce[1] &&
    portPol[1] == POL_READ_FIRST |=> dataOut[1] == $past(memRdData[1]))
    else $error("old-data-then-write output wrong");
  AST_NO_CHANGE: assert property (!globalSetReset && portWrite[0] && !outputForce[0] &&
    portPol[0] == POL_NO_CHANGE |=> $stable(dataOut[0]) && $stable(extraBitsOut[0]))
    else $error("hold-on-write output moved");
  AST_INVALID: assert property (!globalSetReset && portGo[0] && !portWe[0] &&
    !outputForce[0] && portWrite[1] && portAddr[1] == portAddr[0] &&
    portPol[1] != POL_READ_FIRST |=> outInvalid[0])
    else $error("collision not flagged invalid");
  AST_DISABLED: assert property (!portEn[1] && !globalSetReset
    |=> $stable(dataOut[1]) && $stable(extraBitsOut[1]))
    else $error("disabled port changed outputs");
  AST_UNDEFINED: assert property (!outDefined[0] && !globalSetReset && !portGo[0]
    |=> !outDefined[0])
    else $error("latch defined too early");

  COV_PRELOAD: cover property ($rose(preloadDone));
  COV_COLLIDE: cover property (portWrite[0] && portGo[1] && portAddr[0] == portAddr[1]);
  COV_FORCE_WRITE: cover property (portWrite[0] && outputForce[0]);
  COV_READ_AFTER_WRITE: cover property (portWrite[1] ##1 portGo[1] && !portWe[1]);
endmodule

// ### test/dpbr_user_model.sv
`timescale 1ns/1ps
module dpbr_user_model
  import dpbr_pkg::*;
(
  // port controls
  output logic en,
  output logic we,
  output logic frc,
  // address and data
  output logic [dpbr_pkg::ADDR_W-1:0] addr,
  output logic [dpbr_pkg::DATA_W-1:0] din,
  output logic [dpbr_pkg::EXTRA_W-1:0] xin
);
  initial begin
    en = 1'b0;
    we = 1'b0;
    frc = 1'b0;
    addr = '0;
    din = '0;
    xin = '0;
  end
  // called just after a rising edge; values stand until the next call
  task drive(input logic e, w, f, input logic [ADDR_W-1:0] a,
             input logic [DATA_W-1:0] d, input logic [EXTRA_W-1:0] x);
    en <= e;
    we <= w;
    frc <= f;
    if (e) begin
      addr <= a;
      din <= d;
      xin <= x;
    end else begin
      // an unused port carries no stale values
      addr <= ~addr;
      din <= ~din;
      xin <= ~xin;
    end
  endtask
endmodule

// ### test/tb_dual_port_block_ram_datapath.sv
`timescale 1ns/1ps
`define CHK(n, g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb_dual_port_block_ram_datapath;
  import dpbr_pkg::*;
  typedef struct {int due; int p; logic [31:0] d; logic [3:0] x; logic inv;} dpbr_exp_t;
  function automatic logic [CONTENT_BITS-1:0] mkc();
    logic [CONTENT_BITS-1:0] r;
    for (int i = 0; i < DEPTH; i++) r[i*32+:32] = {7'h2a, 9'(i), 8'(~i), 8'(i)};
    return r;
  endfunction
  function automatic logic [EXTRA_BITS-1:0] mkx();
    logic [EXTRA_BITS-1:0] r;
    for (int i = 0; i < DEPTH; i++) r[i*4+:4] = 4'(i) ^ 4'ha;
    return r;
  endfunction
  localparam logic [CONTENT_BITS-1:0] PREC = mkc();
  localparam logic [EXTRA_BITS-1:0] PREX = mkx();
  logic clk_sys, reset_n, psel, penable, pwrite, globalSetReset, pready, pslverr, preloadDone;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] en, we, frc, outInvalid, outDefined;
  logic [1:0][8:0] addr;
  logic [1:0][31:0] din, dataOut;
  logic [1:0][3:0] xin, extraBitsOut;
  int num_errors = 0, total_checks = 0, cyc = 0, seed = 79;
  logic [31:0] memD [DEPTH], outD [2], frcD [2], stD [2];
  logic [3:0] memX [DEPTH], outX [2], frcX [2], stX [2];
  logic [1:0] pol [2];
  logic inv [2];
  dpbr_exp_t q [$], m;

  dpbr_top #(.CONTENT_PRELOAD_WORDS(PREC), .EXTRA_PRELOAD_WORDS(PREX)) DUT (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .globalSetReset(globalSetReset), .portEn(en), .portWe(we), .outputForce(frc),
    .portAddr(addr), .writeWordIn(din), .extraBitsIn(xin), .dataOut(dataOut),
    .extraBitsOut(extraBitsOut), .outInvalid(outInvalid), .outDefined(outDefined),
    .preloadDone(preloadDone));
  dpbr_user_model U0 (.en(en[0]), .we(we[0]), .frc(frc[0]), .addr(addr[0]), .din(din[0]),
    .xin(xin[0]));
  dpbr_user_model U1 (.en(en[1]), .we(we[1]), .frc(frc[1]), .addr(addr[1]), .din(din[1]),
    .xin(xin[1]));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      num_errors++;
      results();
    end
  end
  // compares each port's latch against the oldest note once it is due
  always @(negedge clk_sys) begin
    while (q.size() > 0 && q[0].due <= cyc) begin
      m = q.pop_front();
      `CHK("outInvalid", outInvalid[m.p], m.inv)
      if (!m.inv) begin
        `CHK("dataOut", dataOut[m.p], m.d)
        `CHK("extraBitsOut", extraBitsOut[m.p], m.x)
      end
    end
  end

  function logic [31:0] r32();
    return $random(seed);
  endfunction
  task results();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd, ex,
                     input logic er);
    @(posedge clk_sys);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    if (!w) `CHK("prdata", prdata, ex)
    `CHK("pslverr", pslverr, er)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic setPol(input logic [1:0] a, b);
    pol[0] = a;
    pol[1] = b;
    apb(OFS_CTRL, 1'b1, {28'h0, b, a}, '0, 1'b0);
  endtask
  task automatic step(input logic [1:0] e, w, f, input logic [8:0] a0, a1,
                      input logic [31:0] d0, d1, input logic [3:0] x0, x1);
    logic [8:0] a [2];
    logic [31:0] d [2];
    logic [3:0] x [2];
    int o;
    a = '{a0, a1};
    d = '{d0, d1};
    x = '{x0, x1};
    @(posedge clk_sys);
    U0.drive(e[0], w[0], f[0], a0, d0, x0);
    U1.drive(e[1], w[1], f[1], a1, d1, x1);
    for (int p = 0; p < 2; p++) begin
      o = 1 - p;
      if (e[p]) begin
        inv[p] = e[o] && w[o] && a[o] == a[p] && pol[o] != 2'h1 && !f[p]
                 && !(w[p] && pol[p] == 2'h2);
        if (f[p]) begin
          outD[p] = frcD[p];
          outX[p] = frcX[p];
        end else if (!w[p] || pol[p] == 2'h1) begin
          outD[p] = memD[a[p]];
          outX[p] = memX[a[p]];
        end else if (pol[p] != 2'h2) begin
          outD[p] = d[p];
          outX[p] = x[p];
        end
      end
      q.push_back('{cyc + 2, p, outD[p], outX[p], inv[p]});
    end
    for (int p = 0; p < 2; p++) begin
      if (e[p] && w[p]) begin
        memD[a[p]] = d[p];
        memX[a[p]] = x[p];
      end
    end
  endtask

  initial begin
    logic [8:0] ad;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    globalSetReset = 1'b0;
    pol = '{2'h0, 2'h0};
    inv = '{1'b0, 1'b0};
    for (int i = 0; i < DEPTH; i++) begin
      memD[i] = PREC[i*32+:32];
      memX[i] = PREX[i*4+:4];
    end
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    apb(OFS_STATUS, 1'b0, '0, 32'h0, 1'b0);
    apb(OFS_CTRL, 1'b0, '0, CTRL_RESET, 1'b0);
    apb(OFS_START_A, 1'b0, '0, VALUE_RESET, 1'b0);
    apb(8'h1c, 1'b0, '0, 32'h0, 1'b1);
    apb(OFS_STATUS, 1'b1, 32'hffff, '0, 1'b1);
    for (int n = 0; n < 700 && preloadDone !== 1'b1; n++) @(posedge clk_sys);
    apb(OFS_STATUS, 1'b0, '0, 32'h1, 1'b0);
    $display("test registers done");
    for (int k = 0; k < 8; k++) step(2'h3, 2'h0, 2'h0, 9'(r32()), 9'(r32()), '0, '0, '0, '0);
    apb(OFS_STATUS, 1'b0, '0, 32'h7, 1'b0);
    $display("test preload done");
    for (int k = 0; k < 4; k++) begin
      setPol(2'(k), 2'(k));
      ad = 9'(16 + k);
      step(2'h3, 2'h0, 2'h0, ad, ad ^ 9'h100, '0, '0, '0, '0);
      repeat (2) step(2'h3, 2'h3, 2'h0, ad, ad ^ 9'h100, r32(), r32(), 4'(r32()), 4'(r32()));
      step(2'h3, 2'h0, 2'h0, ad, ad ^ 9'h100, '0, '0, '0, '0);
    end
    $display("test policies done");
    frcD = '{r32(), r32()};
    stD = '{r32(), r32()};
    frcX = '{4'h5, 4'hc};
    stX = '{4'h3, 4'he};
    apb(OFS_FORCE_A, 1'b1, frcD[0], '0, 1'b0);
    apb(OFS_FORCE_B, 1'b1, frcD[1], '0, 1'b0);
    apb(OFS_START_A, 1'b1, stD[0], '0, 1'b0);
    apb(OFS_START_B, 1'b1, stD[1], '0, 1'b0);
    apb(OFS_EXTRA, 1'b1, {16'h0, stX[1], stX[0], frcX[1], frcX[0]}, '0, 1'b0);
    apb(OFS_FORCE_B, 1'b0, '0, frcD[1], 1'b0);
    step(2'h3, 2'h3, 2'h3, 9'h40, 9'h41, r32(), r32(), 4'h1, 4'h2);
    step(2'h3, 2'h0, 2'h3, 9'h40, 9'h41, '0, '0, '0, '0);
    step(2'h3, 2'h0, 2'h0, 9'h40, 9'h41, '0, '0, '0, '0);
    $display("test force done");
    step(2'h0, 2'h3, 2'h3, 9'h40, 9'h41, r32(), r32(), 4'h6, 4'h7);
    step(2'h3, 2'h0, 2'h0, 9'h40, 9'h41, '0, '0, '0, '0);
    $display("test disabled done");
    @(posedge clk_sys);
    globalSetReset <= 1'b1;
    U0.drive(1'b0, 1'b0, 1'b0, '0, '0, '0);
    U1.drive(1'b0, 1'b0, 1'b0, '0, '0, '0);
    for (int p = 0; p < 2; p++) begin
      outD[p] = stD[p];
      outX[p] = stX[p];
      inv[p] = 1'b0;
      q.push_back('{cyc + 2, p, stD[p], stX[p], 1'b0});
    end
    @(posedge clk_sys);
    globalSetReset <= 1'b0;
    step(2'h3, 2'h0, 2'h0, 9'h40, 9'h41, '0, '0, '0, '0);
    $display("test set reset done");
    for (int k = 0; k < 3; k++) begin
      setPol(2'(k), 2'(k));
      step(2'h3, 2'h1, 2'h0, 9'h55, 9'h55, r32(), '0, 4'h9, '0);
      step(2'h3, 2'h2, 2'h0, 9'h55, 9'h55, '0, r32(), '0, 4'h6);
      step(2'h3, 2'h0, 2'h0, 9'h55, 9'h56, '0, '0, '0, '0);
    end
    $display("test collision done");
    setPol(2'h0, 2'h2);
    for (int k = 0; k < 40; k++) begin
      ad = 9'(r32());
      step(2'(r32()), 2'(r32()), 2'(r32()), ad, ad ^ 9'h100, r32(), r32(), 4'(r32()),
           4'(r32()));
    end
    repeat (3) @(posedge clk_sys);
    $display("test random done");
    results();
  end
endmodule
